// file: sac_pkg.sv
// constants shared by the converter control sequencer
// assumes an 8-bit special-function register bus and a 250 MHz system clock
package sac_pkg;
  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] ADDR_INPUT_PAIR_CONFIG = 8'h00_BA;
  localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'h00_BB;
  localparam logic [7:0] ADDR_CONVERTER_CONFIG = 8'h00_BC;
  localparam logic [7:0] ADDR_RESULT_LOW_BYTE = 8'h00_BE;
  localparam logic [7:0] ADDR_RESULT_HIGH_BYTE = 8'h00_BF;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'h00_E8;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_INPUT_PAIR_CONFIG = 8'h00_00;
  localparam logic [7:0] RST_CHANNEL_SELECT = 8'h00_00;
  localparam logic [7:0] RST_CONVERTER_CONFIG = 8'h00_F8;
  localparam logic [7:0] RST_RESULT = 8'h00_00;
  localparam logic [7:0] RST_CONVERTER_CONTROL = 8'h00_00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTL_ENABLE = 7;
  localparam int CTL_TRACK_MODE = 6;
  localparam int CTL_DONE = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_MODE_HI = 3;
  localparam int CTL_MODE_LO = 2;
  localparam int CTL_WINDOW = 1;
  localparam int CTL_LJUST = 0;
  localparam int CFG_PERIOD_HI = 7;
  localparam int CFG_PERIOD_LO = 3;
  localparam int CFG_GAIN_HI = 2;
  localparam int CHAN_TEMP_BIT = 3;

  // ****************************************
  // start modes
  // ****************************************
  localparam logic [1:0] MODE_BUSY_WRITE = 2'h0;
  localparam logic [1:0] MODE_TIMER3 = 2'h1;
  localparam logic [1:0] MODE_EXT_PIN = 2'h2;
  localparam logic [1:0] MODE_TIMER2 = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int TRACK_SAR_CLOCKS = 3;
  localparam int CONVERT_SAR_CLOCKS = 16;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SETTLE_NS_X10 = 15;
  localparam int SETTLE_CYCLES = (SETTLE_NS_X10 * 100000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_TRACK = 3'b010,
    SAC_CONVERT = 3'b100
  } sac_state_e;
endpackage

// file: sac_sequencer.sv
// converter control sequencer: mux, gain and clock setup, start and track sequencing, result formatting
// assumes a synchronous special-function register bus, timer overflow pulses and an analog core
// that returns a straight binary code when the sequence ends
module sac_sequencer #(
  parameter int SETTLE_COUNT = sac_pkg::SETTLE_CYCLES
) (
  input wire logic clk_in, // system clock
  input wire logic arst_n_in, // asynchronous reset, active low
  input wire logic [7:0] sfr_addr_in, // register address
  input wire logic sfr_wr_in, // register write strobe
  input wire logic [7:0] sfr_wdata_in, // register write data
  output logic [7:0] sfr_rdata_out, // read data, one cycle after address
  input wire logic timer3_overflow_in, // third timer overflow pulse
  input wire logic timer2_overflow_in, // second timer overflow pulse
  input wire logic external_start_pin_in, // external start pin level
  input wire logic window_match_in, // window comparator match pulse
  input wire logic [9:0] core_code_in, // straight binary code from the core
  output logic converter_enable_out, // analog core powered
  output logic track_out, // track-and-hold tracking
  output logic convert_out, // core converting
  output logic sar_clock_tick_out, // one pulse per sar clock
  output logic [3:0] channel_address_out, // mux channel
  output logic temp_sensor_select_out, // temperature sensor routed
  output logic differential_out, // selected pair is differential
  output logic [2:0] amplifier_gain_code_out, // amplifier gain
  output logic mux_settled_out // settle time passed since mux or gain change
);

  // ****************************************
  // registers
  // ****************************************
  logic [3:0] input_pair_config_reg;
  logic [3:0] channel_select_reg;
  logic [7:0] converter_config_reg;
  logic [7:0] result_low_byte_reg;
  logic [7:0] result_high_byte_reg;
  logic converter_enable_reg;
  logic track_mode_reg;
  logic conversion_done_flag_reg;
  logic [1:0] start_mode_reg;
  logic window_match_flag_reg;
  logic left_justify_select_reg;
  sac_pkg::sac_state_e state_reg;
  sac_pkg::sac_state_e state_next;
  logic [5:0] div_cnt_reg;
  logic [4:0] tick_cnt_reg;
  logic sar_tick_reg;
  logic pin_prev_reg;
  logic diff_latched_reg;
  logic [8:0] settle_cnt_reg;

  logic wr_ctl;
  logic busy;
  logic pin_rise;
  logic trigger;
  logic finish;
  logic [4:0] sar_clock_period;
  logic [5:0] div_last;
  logic selected_diff;
  logic [9:0] code_twos;

  assign wr_ctl = sfr_wr_in && (sfr_addr_in == sac_pkg::ADDR_CONVERTER_CONTROL);
  assign busy = (state_reg != sac_pkg::SAC_IDLE);
  assign pin_rise = external_start_pin_in && !pin_prev_reg;
  assign sar_clock_period = converter_config_reg[sac_pkg::CFG_PERIOD_HI:sac_pkg::CFG_PERIOD_LO];
  // code with top bit set picks the sensor; odd member of a differential pair maps to its pair
  assign selected_diff = !channel_select_reg[sac_pkg::CHAN_TEMP_BIT] &&
                         input_pair_config_reg[channel_select_reg[2:1]];
  // core code is offset binary for differential inputs; flipping the msb gives two's complement
  assign code_twos = {core_code_in[9] ^ diff_latched_reg, core_code_in[8:0]};

  // ****************************************
  // sar clock divider
  // ****************************************
  always_comb begin
    if (sar_clock_period == 5'h0_0) begin
      div_last = 6'h0_0;
    end else begin
      div_last = 6'(({1'b0, sar_clock_period} << 1) + 6'h0_1);
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt_reg <= 6'h0_0;
      sar_tick_reg <= 1'b0;
    end else begin
      // counter restarts at a trigger so the track phase lasts whole sar clocks
      if (trigger || div_cnt_reg >= div_last) begin
        div_cnt_reg <= 6'h0_0;
      end else begin
        div_cnt_reg <= div_cnt_reg + 6'h0_1;
      end
      sar_tick_reg <= !trigger && (div_cnt_reg >= div_last);
    end
  end

  // ****************************************
  // start of conversion
  // ****************************************
  always_comb begin
    case (start_mode_reg)
      sac_pkg::MODE_BUSY_WRITE: trigger = wr_ctl && sfr_wdata_in[sac_pkg::CTL_BUSY];
      sac_pkg::MODE_TIMER3: trigger = timer3_overflow_in;
      sac_pkg::MODE_EXT_PIN: trigger = pin_rise;
      sac_pkg::MODE_TIMER2: trigger = timer2_overflow_in;
      default: trigger = 1'b0;
    endcase
    trigger = trigger && converter_enable_reg && !busy;
  end

  assign finish = (state_reg == sac_pkg::SAC_CONVERT) && sar_tick_reg &&
                  (tick_cnt_reg == 5'(sac_pkg::CONVERT_SAR_CLOCKS - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sac_pkg::SAC_IDLE: begin
        if (trigger) begin
          // pin mode has already tracked while the pin was low
          if (track_mode_reg && start_mode_reg != sac_pkg::MODE_EXT_PIN) begin
            state_next = sac_pkg::SAC_TRACK;
          end else begin
            state_next = sac_pkg::SAC_CONVERT;
          end
        end
      end
      sac_pkg::SAC_TRACK: begin
        if (sar_tick_reg && tick_cnt_reg == 5'(sac_pkg::TRACK_SAR_CLOCKS - 1)) begin
          state_next = sac_pkg::SAC_CONVERT;
        end
      end
      sac_pkg::SAC_CONVERT: begin
        if (finish) begin
          state_next = sac_pkg::SAC_IDLE;
        end
      end
      default: state_next = sac_pkg::SAC_IDLE;
    endcase
    if (!converter_enable_reg) begin
      state_next = sac_pkg::SAC_IDLE;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= sac_pkg::SAC_IDLE;
      tick_cnt_reg <= 5'h0_0;
      diff_latched_reg <= 1'b0;
      pin_prev_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      pin_prev_reg <= external_start_pin_in;
      if (state_next != state_reg) begin
        tick_cnt_reg <= 5'h0_0;
      end else if (sar_tick_reg) begin
        tick_cnt_reg <= tick_cnt_reg + 5'h0_1;
      end
      if (trigger) begin
        diff_latched_reg <= selected_diff;
      end
    end
  end

  // ****************************************
  // register writes and flags
  // ****************************************
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      input_pair_config_reg <= sac_pkg::RST_INPUT_PAIR_CONFIG[3:0];
      channel_select_reg <= sac_pkg::RST_CHANNEL_SELECT[3:0];
      converter_config_reg <= sac_pkg::RST_CONVERTER_CONFIG;
    end else if (sfr_wr_in) begin
      if (sfr_addr_in == sac_pkg::ADDR_INPUT_PAIR_CONFIG) begin
        input_pair_config_reg <= sfr_wdata_in[3:0];
      end
      if (sfr_addr_in == sac_pkg::ADDR_CHANNEL_SELECT) begin
        channel_select_reg <= sfr_wdata_in[3:0];
      end
      if (sfr_addr_in == sac_pkg::ADDR_CONVERTER_CONFIG) begin
        converter_config_reg <= sfr_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      converter_enable_reg <= sac_pkg::RST_CONVERTER_CONTROL[sac_pkg::CTL_ENABLE];
      track_mode_reg <= sac_pkg::RST_CONVERTER_CONTROL[sac_pkg::CTL_TRACK_MODE];
      start_mode_reg <= sac_pkg::RST_CONVERTER_CONTROL[sac_pkg::CTL_MODE_HI:sac_pkg::CTL_MODE_LO];
      left_justify_select_reg <= sac_pkg::RST_CONVERTER_CONTROL[sac_pkg::CTL_LJUST];
    end else if (wr_ctl) begin
      converter_enable_reg <= sfr_wdata_in[sac_pkg::CTL_ENABLE];
      track_mode_reg <= sfr_wdata_in[sac_pkg::CTL_TRACK_MODE];
      start_mode_reg <= sfr_wdata_in[sac_pkg::CTL_MODE_HI:sac_pkg::CTL_MODE_LO];
      left_justify_select_reg <= sfr_wdata_in[sac_pkg::CTL_LJUST];
    end
  end

  // hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conversion_done_flag_reg <= sac_pkg::RST_CONVERTER_CONTROL[sac_pkg::CTL_DONE];
      window_match_flag_reg <= sac_pkg::RST_CONVERTER_CONTROL[sac_pkg::CTL_WINDOW];
    end else begin
      if (finish) begin
        conversion_done_flag_reg <= 1'b1;
      end else if (wr_ctl) begin
        conversion_done_flag_reg <= sfr_wdata_in[sac_pkg::CTL_DONE];
      end
      if (window_match_in) begin
        window_match_flag_reg <= 1'b1;
      end else if (wr_ctl) begin
        window_match_flag_reg <= sfr_wdata_in[sac_pkg::CTL_WINDOW];
      end
    end
  end

  // ****************************************
  // result bytes
  // ****************************************
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      result_low_byte_reg <= sac_pkg::RST_RESULT;
      result_high_byte_reg <= sac_pkg::RST_RESULT;
    end else if (finish) begin
      // justification is sampled at the end, so a change mid-conversion takes effect on this result
      if (left_justify_select_reg) begin
        result_high_byte_reg <= code_twos[9:2];
        result_low_byte_reg <= {code_twos[1:0], 6'h0_0};
      end else begin
        result_high_byte_reg <= {{6{code_twos[9] & diff_latched_reg}}, code_twos[9:8]};
        result_low_byte_reg <= code_twos[7:0];
      end
    end else if (sfr_wr_in) begin
      if (sfr_addr_in == sac_pkg::ADDR_RESULT_LOW_BYTE) begin
        result_low_byte_reg <= sfr_wdata_in;
      end
      if (sfr_addr_in == sac_pkg::ADDR_RESULT_HIGH_BYTE) begin
        result_high_byte_reg <= sfr_wdata_in;
      end
    end
  end

  // ****************************************
  // settle monitor
  // ****************************************
  // software still owns the settle wait; this only reports it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      settle_cnt_reg <= 9'h0_00;
      mux_settled_out <= 1'b0;
    end else begin
      if (sfr_wr_in && (sfr_addr_in == sac_pkg::ADDR_CHANNEL_SELECT ||
                        sfr_addr_in == sac_pkg::ADDR_INPUT_PAIR_CONFIG ||
                        sfr_addr_in == sac_pkg::ADDR_CONVERTER_CONFIG)) begin
        settle_cnt_reg <= 9'h0_00;
        mux_settled_out <= 1'b0;
      end else if (settle_cnt_reg < 9'(SETTLE_COUNT - 1)) begin
        settle_cnt_reg <= settle_cnt_reg + 9'h0_01;
      end else begin
        mux_settled_out <= 1'b1;
      end
    end
  end

  // ****************************************
  // outputs and read data
  // ****************************************
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      converter_enable_out <= 1'b0;
      track_out <= 1'b0;
      convert_out <= 1'b0;
      sar_clock_tick_out <= 1'b0;
      channel_address_out <= 4'h0;
      temp_sensor_select_out <= 1'b0;
      differential_out <= 1'b0;
      amplifier_gain_code_out <= 3'h0;
      sfr_rdata_out <= 8'h00_00;
    end else begin
      converter_enable_out <= converter_enable_reg;
      convert_out <= (state_reg == sac_pkg::SAC_CONVERT);
      if (!converter_enable_reg) begin
        track_out <= 1'b0;
      end else if (!track_mode_reg) begin
        track_out <= (state_reg != sac_pkg::SAC_CONVERT);
      end else if (start_mode_reg == sac_pkg::MODE_EXT_PIN) begin
        track_out <= (state_reg == sac_pkg::SAC_IDLE) && !external_start_pin_in;
      end else begin
        track_out <= (state_reg == sac_pkg::SAC_TRACK);
      end
      sar_clock_tick_out <= sar_tick_reg;
      channel_address_out <= channel_select_reg;
      temp_sensor_select_out <= channel_select_reg[sac_pkg::CHAN_TEMP_BIT];
      differential_out <= selected_diff;
      amplifier_gain_code_out <= converter_config_reg[sac_pkg::CFG_GAIN_HI:0];
      case (sfr_addr_in)
        sac_pkg::ADDR_INPUT_PAIR_CONFIG: sfr_rdata_out <= {4'h0, input_pair_config_reg};
        sac_pkg::ADDR_CHANNEL_SELECT: sfr_rdata_out <= {4'h0, channel_select_reg};
        sac_pkg::ADDR_CONVERTER_CONFIG: sfr_rdata_out <= converter_config_reg;
        sac_pkg::ADDR_RESULT_LOW_BYTE: sfr_rdata_out <= result_low_byte_reg;
        sac_pkg::ADDR_RESULT_HIGH_BYTE: sfr_rdata_out <= result_high_byte_reg;
        sac_pkg::ADDR_CONVERTER_CONTROL: sfr_rdata_out <= {converter_enable_reg, track_mode_reg,
                                                           conversion_done_flag_reg, busy, start_mode_reg,
                                                           window_match_flag_reg, left_justify_select_reg};
        default: sfr_rdata_out <= 8'h00_00;
      endcase
    end
  end

endmodule

// file: sac_core_model.sv
// analog core stand-in facing the sequencer's core code input
// assumes the bench loads the wanted code before each trigger
module sac_core_model (
  input wire logic convert_in, // core converting
  input wire logic [9:0] code_in, // code the bench wants converted
  output logic [9:0] core_code_out // code seen by the sequencer
);
  timeunit 1ns;
  timeprecision 1ps;
  // outside a conversion the code is inverted, so a stale sample shows as a wrong result
  assign core_code_out = convert_in ? code_in : ~code_in;
endmodule

// file: sac_seq_asserts.sv
// port checker for the converter control sequencer
// assumes it is bound to sac_sequencer; one clock, asynchronous active-low reset
module sac_seq_asserts #(
  parameter int SETTLE_COUNT = 8
) (
  input wire logic clk_in, // system clock
  input wire logic arst_n_in, // reset, active low
  input wire logic [7:0] sfr_addr_in, // register address
  input wire logic sfr_wr_in, // write strobe
  input wire logic [7:0] sfr_wdata_in, // write data
  input wire logic [7:0] sfr_rdata_out, // read data
  input wire logic converter_enable_out, // core powered
  input wire logic track_out, // tracking
  input wire logic convert_out, // converting
  input wire logic [3:0] channel_address_out, // mux channel
  input wire logic temp_sensor_select_out, // sensor routed
  input wire logic [2:0] amplifier_gain_code_out, // gain
  input wire logic mux_settled_out // settle time passed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ****************************************
  // settle counter
  // ****************************************
  logic cfg_wr;
  int since_cfg;
  assign cfg_wr = sfr_wr_in && (sfr_addr_in inside {8'h00_BA, 8'h00_BB, 8'h00_BC});
  // saturates so a long idle spell cannot wrap
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) since_cfg <= 0;
    else if (cfg_wr) since_cfg <= 0;
    else if (since_cfg < SETTLE_COUNT + 4) since_cfg <= since_cfg + 1;
  end
  // ****************************************
  // properties
  // ****************************************
  a_settle_not_early: assert property (mux_settled_out |-> since_cfg >= SETTLE_COUNT - 2)
    else $error("settled flag rose too early");
  a_settle_not_late: assert property (since_cfg > SETTLE_COUNT + 2 |-> mux_settled_out)
    else $error("settled flag missing");
  a_enable_follows_write: assert property (sfr_wr_in && sfr_addr_in == 8'h00_E8 |-> ##2
    converter_enable_out == $past(sfr_wdata_in[7], 2)) else $error("enable output wrong");
  a_gain_follows_write: assert property (sfr_wr_in && sfr_addr_in == 8'h00_BC |-> ##2
    amplifier_gain_code_out == $past(sfr_wdata_in[2:0], 2)) else $error("gain output wrong");
  a_channel_follows_write: assert property (sfr_wr_in && sfr_addr_in == 8'h00_BB |-> ##2
    channel_address_out == $past(sfr_wdata_in[3:0], 2)) else $error("channel output wrong");
  a_temp_from_bit: assert property (temp_sensor_select_out == channel_address_out[3])
    else $error("sensor select disagrees with channel");
  a_hold_not_both: assert property (!(track_out && convert_out))
    else $error("tracking while converting");
  a_off_is_quiet: assert property (!converter_enable_out [*3] |-> !convert_out && !track_out)
    else $error("activity while disabled");
  a_busy_reads_one: assert property (convert_out && $past(sfr_addr_in) == 8'h00_E8
    |-> sfr_rdata_out[sac_pkg::CTL_BUSY]) else $error("busy bit low during conversion");
  c_conv_end: cover property ($fell(convert_out));
  c_track_then_conv: cover property (track_out ##1 convert_out);
  c_settled: cover property ($rose(mux_settled_out));
endmodule

// file: tb.sv
// self-checking bench for the converter control sequencer
// assumes sac_pkg, sac_sequencer, sac_core_model and sac_seq_asserts are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = sac_pkg::ADDR_CONVERTER_CONTROL;
  logic clk_in = 0, arst_n_in = 0, sfr_wr_in = 0, t3 = 0, t2 = 0, pin = 1, win = 0;
  logic [7:0] sfr_addr_in = 0, sfr_wdata_in = 0, sfr_rdata_out;
  logic [9:0] code = 0, core_code;
  logic en, trk, cnv, tick, temp, diff, settled;
  logic [3:0] chan;
  logic [2:0] gain;
  int n_fail = 0, comparisons = 0, n_conv = 0, n_trk = 0, n_tick = 0;
  always #2 clk_in = ~clk_in;
  sac_sequencer #(.SETTLE_COUNT(8)) i_sac_sequencer (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .timer3_overflow_in(t3), .timer2_overflow_in(t2), .external_start_pin_in(pin), .window_match_in(win),
    .core_code_in(core_code), .converter_enable_out(en), .track_out(trk), .convert_out(cnv),
    .sar_clock_tick_out(tick), .channel_address_out(chan), .temp_sensor_select_out(temp),
    .differential_out(diff), .amplifier_gain_code_out(gain), .mux_settled_out(settled));
  sac_core_model i_sac_core_model (.convert_in(cnv), .code_in(code), .core_code_out(core_code));
  always @(posedge clk_in) begin
    if (cnv === 1'b1) n_conv++;
    if (trk === 1'b1) n_trk++;
    if (cnv === 1'b1 && tick === 1'b1) n_tick++;
  end
  // ****************************************
  // access tasks
  // ****************************************
  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // every write leaves an idle cycle behind it, so the strobe is never driven twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1;
    @(negedge clk_in);
    sfr_wr_in = 0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_in = a;
    @(negedge clk_in);
    d = sfr_rdata_out;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("register %h", a), d & m, e);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clk_in);
    s = 0;
  endtask
  function automatic logic [7:0] ctl(input logic tm, input logic b, input logic [1:0] m, input logic lj);
    return {1'b1, tm, 1'b0, b, m, 1'b0, lj};
  endfunction
  task automatic conv(input logic [4:0] p, input logic tm, input logic [1:0] m, input logic lj,
                      input logic [9:0] c, input logic [15:0] exp);
    logic [7:0] hi, lo, s;
    int per;
    per = (p == 0) ? 1 : 2 * (p + 1);
    wr(sac_pkg::ADDR_CONVERTER_CONFIG, {p, 3'h0});
    wr(CTL, ctl(tm, 0, m, lj));
    code = c;
    n_conv = 0;
    n_trk = 0;
    n_tick = 0;
    case (m)
      2'h0: wr(CTL, ctl(tm, 1, m, lj));
      2'h1: pulse(t3);
      2'h2: begin
        pin = 0;
        repeat (4) @(negedge clk_in);
        chk("track while pin low", trk, 1);
        pin = 1;
        @(negedge clk_in);
      end
      default: pulse(t2);
    endcase
    rc(CTL, 8'h10, 8'h10);
    s = 0;
    for (int i = 0; i < 400 && s[5] !== 1'b1; i++) rd(CTL, s);
    chk("done and busy", s & 8'h30, 8'h20);
    rd(sac_pkg::ADDR_RESULT_HIGH_BYTE, hi);
    rd(sac_pkg::ADDR_RESULT_LOW_BYTE, lo);
    chk("result", {hi, lo}, exp);
    // the trigger cycle itself comes before the first sar clock of whichever phase follows it
    chk("convert cycles", n_conv, (tm && m != 2'h2) ? 16 * per : 16 * per + 1);
    chk("sar ticks in conversion", n_tick, 16);
    if (tm && m != 2'h2) chk("track cycles", n_trk, 3 * per + 1);
    if (!tm) chk("idle tracking", trk, 1);
    rc(CTL, 8'h20, 8'h20);
    wr(CTL, ctl(tm, 0, m, lj));
    rc(CTL, 8'h20, 8'h00);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (16) @(negedge clk_in);
    arst_n_in = 1;
    rc(8'h00_BA, 8'h00_FF, 8'h00_00);
    rc(8'h00_BB, 8'h00_FF, 8'h00_00);
    rc(8'h00_BC, 8'h00_FF, 8'h00_F8);
    rc(8'h00_BE, 8'h00_FF, 8'h00_00);
    rc(8'h00_BF, 8'h00_FF, 8'h00_00);
    rc(CTL, 8'h00_FF, 8'h00_00);
    rc(8'h00_00, 8'h00_FF, 8'h00_00);
    wr(8'h00_BA, 8'h00_FF);
    rc(8'h00_BA, 8'h00_FF, 8'h00_0F);
    wr(8'h00_BB, 8'h00_FF);
    rc(8'h00_BB, 8'h00_FF, 8'h00_0F);
    chk("sensor select", temp, 1);
    for (int k = 0; k < 16; k++) begin
      wr(8'h00_BA, k[7:0]);
      for (int c = 0; c < 8; c++) begin
        wr(8'h00_BB, c[7:0]);
        chk("differential", diff, k[c / 2]);
        chk("channel", chan, c[3:0]);
      end
    end
    for (int g = 0; g < 8; g++) begin
      wr(8'h00_BC, g[7:0]);
      chk("gain", gain, g[2:0]);
    end
    wr(8'h00_BA, 8'h00_00);
    wr(8'h00_BB, 8'h00_00);
    wr(CTL, ctl(0, 0, 1, 0));
    wr(CTL, ctl(0, 1, 1, 0));
    rc(CTL, 8'h10, 8'h00);
    pulse(t2);
    rc(CTL, 8'h10, 8'h00);
    conv(0, 0, 0, 0, 10'h3FF, 16'h03FF);
    conv(1, 0, 1, 1, 10'h3FF, 16'hFFC0);
    conv(0, 1, 0, 0, 10'h201, 16'h0201);
    conv(2, 1, 3, 1, 10'h1FF, 16'h7FC0);
    conv(0, 1, 2, 0, 10'h155, 16'h0155);
    wr(8'h00_BA, 8'h00_01);
    conv(0, 0, 2, 0, 10'h1FF, 16'hFFFF);
    conv(0, 0, 0, 1, 10'h1FF, 16'hFFC0);
    conv(0, 0, 1, 0, 10'h300, 16'h0100);
    wr(8'h00_BB, 8'h00_01);
    conv(0, 0, 3, 0, 10'h000, 16'hFE00);
    pulse(win);
    rc(CTL, 8'h02, 8'h02);
    repeat (5) @(negedge clk_in);
    rc(CTL, 8'h02, 8'h02);
    wr(CTL, ctl(0, 0, 0, 0));
    rc(CTL, 8'h02, 8'h00);
    wr(8'h00_BC, 8'h00_F8);
    wr(CTL, ctl(0, 1, 0, 0));
    repeat (20) @(negedge clk_in);
    wr(CTL, 8'h00_00);
    repeat (4) @(negedge clk_in);
    rc(CTL, 8'h30, 8'h00);
    rc(8'h00_BF, 8'h00_FF, 8'h00_FE);
    chk("enable", en, 0);
    tally_and_finish();
  end
  initial begin
    repeat (30000) @(posedge clk_in);
    n_fail++;
    tally_and_finish();
  end
endmodule
bind sac_sequencer sac_seq_asserts #(.SETTLE_COUNT(SETTLE_COUNT)) i_sac_seq_asserts (.clk_in(clk_in),
  .arst_n_in(arst_n_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in),
  .sfr_rdata_out(sfr_rdata_out), .converter_enable_out(converter_enable_out), .track_out(track_out),
  .convert_out(convert_out), .channel_address_out(channel_address_out),
  .temp_sensor_select_out(temp_sensor_select_out), .amplifier_gain_code_out(amplifier_gain_code_out),
  .mux_settled_out(mux_settled_out));
